// >>> utx_serial_tx.sv
// Transmit data path, status flags and interrupt gating of the serial transceiver.
`timescale 1ns/1ps
`default_nettype none
module utx_serial_tx
  import utx_pkg::*;
#(
  parameter logic [15:0] CLKS_PER_BIT = CLKS_PER_BIT_DEF
) (
  // Clock, reset and enable
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_RST,
  input  wire logic                  I_CE,
  // AXI4-Lite write channels
  input  wire logic [AXI_ADDR_W-1:0] I_AXI_AWADDR,
  input  wire logic                  I_AXI_AWVALID,
  output logic                       O_AXI_AWREADY,
  input  wire logic [31:0]           I_AXI_WDATA,
  input  wire logic [3:0]            I_AXI_WSTRB,
  input  wire logic                  I_AXI_WVALID,
  output logic                       O_AXI_WREADY,
  output logic [1:0]                 O_AXI_BRESP,
  output logic                       O_AXI_BVALID,
  input  wire logic                  I_AXI_BREADY,
  // AXI4-Lite read channels
  input  wire logic [AXI_ADDR_W-1:0] I_AXI_ARADDR,
  input  wire logic                  I_AXI_ARVALID,
  output logic                       O_AXI_ARREADY,
  output logic [31:0]                O_AXI_RDATA,
  output logic [1:0]                 O_AXI_RRESP,
  output logic                       O_AXI_RVALID,
  input  wire logic                  I_AXI_RREADY,
  // Events and levels from the receiver and auto-baud logic
  input  wire logic                  I_RX_UNREAD,
  input  wire logic                  I_RX_DATA_DONE,
  input  wire logic                  I_SOF_DET,
  input  wire logic                  I_STANDBY,
  input  wire logic                  I_SYNC_BAD_LEN,
  input  wire logic                  I_SYNC_VALID,
  input  wire logic [7:0]            I_SYNC_CHAR,
  input  wire logic                  I_BREAK_SYNC,
  // Serial pins and receiver feed
  input  wire logic                  I_RXD,
  output logic                       O_TXD,
  output logic                       O_RX_LINE,
  output logic                       O_AWAIT_BREAK,
  output logic [1:0]                 O_RX_SPEED_MODE,
  // Interrupt vectors
  output logic                       O_IRQ_RXC,
  output logic                       O_IRQ_DRE,
  output logic                       O_IRQ_TXC
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic reg_hit(input logic [7:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    reg_hit = (a[1:0] == 2'h0) && (idx >= IDX_TX_LOW) && (idx <= IDX_CONFIG);
  endfunction

  function automatic logic [3:0] data_bits(input logic [2:0] cw);
    data_bits = (cw >= CW_NINE_LOW) ? 4'h9 : (cw > 3'h3) ? 4'h8 : 4'(cw) + 4'h5;
  endfunction

  // Unused upper data bits are forced high so they shift out as stop level.
  function automatic logic [8:0] frame_data(input logic [8:0] d, input logic [2:0] cw);
    logic [8:0] f;
    f = d;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) >= data_bits(cw)) begin
        f[i] = 1'b1;
      end
    end
    frame_data = f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  utx_state_t st_reg;
  utx_state_t st_next;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_stat;
  logic       nine_lo;
  logic       adv;
  logic       load;
  logic       frame_end;
  logic       ab_on;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  logic [5:0] rd_idx;

  assign status_byte = {st_reg.rxc, st_reg.txc, ~st_reg.buf_full, st_reg.rxs,
                        st_reg.isf, 1'b0, st_reg.bdf, 1'b0};

  always_comb begin
    st_next   = st_reg;
    wr_en     = 1'b0;
    wr_idx    = st_reg.aw_addr[7:2];
    rd_idx    = I_AXI_ARADDR[7:2];
    rd_byte   = 8'h00;
    frame_end = 1'b0;
    nine_lo   = (st_reg.cfg[2:0] == CW_NINE_LOW);
    ab_on     = (st_reg.cfg[5:4] == MODE_GENERIC_AB) || (st_reg.cfg[5:4] == MODE_LIN_AB);
    wr_lo     = 1'b0;
    wr_hi     = 1'b0;
    wr_stat   = 1'b0;
    adv       = 1'b0;
    load      = 1'b0;
    case (rd_idx)
      IDX_TX_LOW:  rd_byte = st_reg.tx_low;
      IDX_TX_HIGH: rd_byte = {7'h00, st_reg.tx_high};
      IDX_STATUS:  rd_byte = status_byte;
      IDX_CTRL:    rd_byte = st_reg.ctrl;
      IDX_CONFIG:  rd_byte = st_reg.cfg;
      default:     rd_byte = 8'h00;
    endcase
    if (I_CE) begin
      // Write address and data are held independently; the response follows both.
      if (I_AXI_AWVALID && st_reg.aw_rdy) begin
        st_next.aw_full = 1'b1;
        st_next.aw_addr = I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && st_reg.w_rdy) begin
        st_next.w_full  = 1'b1;
        st_next.w_data  = I_AXI_WDATA[7:0];
        st_next.w_strb0 = I_AXI_WSTRB[0];
      end
      if (st_reg.bvalid && I_AXI_BREADY) begin
        st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
        st_next.aw_full = 1'b0;
        st_next.w_full  = 1'b0;
        st_next.bvalid  = 1'b1;
        st_next.bresp   = reg_hit(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
        wr_en           = reg_hit(st_reg.aw_addr) && st_reg.w_strb0;
      end
      if (st_reg.rvalid && I_AXI_RREADY) begin
        st_next.rvalid = 1'b0;
      end
      if (I_AXI_ARVALID && st_reg.ar_rdy) begin
        st_next.rvalid = 1'b1;
        st_next.rdata  = rd_byte;
        st_next.rresp  = reg_hit(I_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end
      st_next.aw_rdy = ~st_next.aw_full;
      st_next.w_rdy  = ~st_next.w_full;
      st_next.ar_rdy = ~st_next.rvalid;

      // Register writes.
      wr_lo   = wr_en && (wr_idx == IDX_TX_LOW);
      wr_hi   = wr_en && (wr_idx == IDX_TX_HIGH);
      wr_stat = wr_en && (wr_idx == IDX_STATUS);
      if (wr_lo) begin
        st_next.tx_low = st_reg.w_data;
      end
      if (wr_hi) begin
        st_next.tx_high = st_reg.w_data[0];
      end
      if (wr_en && (wr_idx == IDX_CTRL)) begin
        st_next.ctrl = st_reg.w_data & CTRL_MASK;
      end
      if (wr_en && (wr_idx == IDX_CONFIG)) begin
        st_next.cfg = st_reg.w_data & CFG_MASK;
      end
      if (wr_stat) begin
        st_next.await_break = st_reg.w_data[BIT_WFB];
      end

      // Buffer advance and hand-off to the shifter.
      adv  = (wr_lo && !nine_lo) || (wr_hi && nine_lo);
      load = st_reg.buf_full && (st_reg.tx_state == TX_IDLE);
      if (load) begin
        st_next.buf_full = 1'b0;
      end
      if (adv) begin
        st_next.buf_full = 1'b1;
        st_next.buf_data = {wr_hi ? st_reg.w_data[0] : st_reg.tx_high,
                            wr_lo ? st_reg.w_data : st_reg.tx_low};
      end

      // Shifter: start bit, data bits least significant first, one stop bit.
      case (st_reg.tx_state)
        TX_IDLE: begin
          if (load) begin
            st_next.tx_state  = TX_SHIFT;
            st_next.sh_data   = frame_data(st_reg.buf_data, st_reg.cfg[2:0]);
            st_next.bits_left = data_bits(st_reg.cfg[2:0]) + 4'h1;
            st_next.baud_cnt  = 16'h0000;
            st_next.txd       = 1'b0;
          end
        end
        TX_SHIFT: begin
          if (st_reg.baud_cnt >= CLKS_PER_BIT - 16'h0001) begin
            st_next.baud_cnt = 16'h0000;
            if (st_reg.bits_left == 4'h0) begin
              st_next.tx_state = TX_IDLE;
              frame_end        = 1'b1;
            end else begin
              st_next.txd       = st_reg.sh_data[0];
              st_next.sh_data   = {1'b1, st_reg.sh_data[8:1]};
              st_next.bits_left = st_reg.bits_left - 4'h1;
            end
          end else begin
            st_next.baud_cnt = st_reg.baud_cnt + 16'h0001;
          end
        end
        default: st_next.tx_state = TX_IDLE;
      endcase

      // Flags: a set in the same cycle as a write-one clear wins.
      st_next.rxc = I_RX_UNREAD;
      st_next.txc = (st_reg.txc & ~(wr_stat & st_reg.w_data[BIT_TXC]))
                  | (frame_end & ~st_reg.buf_full & ~adv);
      st_next.rxs = (st_reg.rxs & ~(wr_stat & st_reg.w_data[BIT_RXS]))
                  | (I_SOF_DET & st_reg.cfg[CFG_SOF_EN] & I_STANDBY
                     & ~st_reg.cfg[CFG_HOST_SPI]);
      st_next.isf = (st_reg.isf & ~(wr_stat & st_reg.w_data[BIT_ISF]))
                  | (ab_on & I_SYNC_BAD_LEN)
                  | ((st_reg.cfg[5:4] == MODE_LIN_AB) & I_SYNC_VALID
                     & (I_SYNC_CHAR != SYNC_CHAR));
      st_next.bdf = (st_reg.bdf & ~(wr_stat & st_reg.w_data[BIT_BDF]) & ~I_RX_DATA_DONE)
                  | (ab_on & I_BREAK_SYNC);

      // Loop-back takes the receiver feed from our own transmit pin.
      st_next.rx_s1   = I_RXD;
      st_next.rx_s2   = st_reg.rx_s1;
      st_next.rx_line = st_reg.ctrl[BIT_LOOP] ? st_reg.txd : st_reg.rx_s2;

      // Interrupts are levels of flag and enable, one register behind neither.
      st_next.irq_rxc = (st_next.rxc & st_next.ctrl[BIT_RXC])
                      | (st_next.rxs & st_next.ctrl[BIT_RXS])
                      | (st_next.isf & st_next.ctrl[BIT_ABE]);
      st_next.irq_dre = ~st_next.buf_full & st_next.ctrl[BIT_DRE];
      st_next.irq_txc = st_next.txc & st_next.ctrl[BIT_TXC];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign O_AXI_AWREADY   = st_reg.aw_rdy;
  assign O_AXI_WREADY    = st_reg.w_rdy;
  assign O_AXI_BRESP     = st_reg.bresp;
  assign O_AXI_BVALID    = st_reg.bvalid;
  assign O_AXI_ARREADY   = st_reg.ar_rdy;
  assign O_AXI_RDATA     = {24'h000000, st_reg.rdata};
  assign O_AXI_RRESP     = st_reg.rresp;
  assign O_AXI_RVALID    = st_reg.rvalid;
  assign O_TXD           = st_reg.txd;
  assign O_RX_LINE       = st_reg.rx_line;
  assign O_AWAIT_BREAK   = st_reg.await_break;
  assign O_RX_SPEED_MODE = st_reg.cfg[5:4];
  assign O_IRQ_RXC       = st_reg.irq_rxc;
  assign O_IRQ_DRE       = st_reg.irq_dre;
  assign O_IRQ_TXC       = st_reg.irq_txc;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  reset_flags_a: assert property ($past(I_RST) |-> status_byte == STATUS_RST)
    else $error("status not at reset value after reset");

  low_advance_a: assert property (I_CE && wr_lo && !nine_lo |=> st_reg.buf_full)
    else $error("low byte write did not fill buffer");

  high_advance_a: assert property (I_CE && wr_hi && nine_lo |=> st_reg.buf_full
                                   && st_reg.buf_data[8] == $past(st_reg.w_data[0]))
    else $error("high byte write did not fill buffer in nine-low mode");

  high_hold_a: assert property (I_CE && wr_hi && !nine_lo && !wr_lo && !load
                                |=> st_reg.buf_full == $past(st_reg.buf_full))
    else $error("high byte write advanced buffer wrongly");

  start_bit_a: assert property (I_CE && load && !adv |=> !O_TXD
                                && st_reg.tx_state == TX_SHIFT && !st_reg.buf_full)
    else $error("frame did not start with low start bit");

  tx_done_a: assert property (I_CE && frame_end && !st_reg.buf_full && !adv
                              |=> st_reg.txc ##1 (st_reg.txc || $past(wr_stat)))
    else $error("transmit complete not set at frame end");

  rx_done_a: assert property (I_CE |=> st_reg.rxc == $past(I_RX_UNREAD))
    else $error("receive complete flag does not follow unread data");

  lin_sync_a: assert property (I_CE && st_reg.cfg[5:4] == MODE_LIN_AB && I_SYNC_VALID
                               && I_SYNC_CHAR != SYNC_CHAR |=> st_reg.isf)
    else $error("bad LIN sync character not flagged");

  break_clr_a: assert property (I_CE && I_RX_DATA_DONE && !(ab_on && I_BREAK_SYNC)
                                |=> !st_reg.bdf)
    else $error("break flag not cleared by received data");

  loop_path_a: assert property (I_CE && st_reg.ctrl[BIT_LOOP]
                                |=> O_RX_LINE == $past(O_TXD))
    else $error("loop-back path not taken from transmit pin");

  txc_irq_a: assert property (O_IRQ_TXC == (st_reg.txc && st_reg.ctrl[BIT_TXC]))
    else $error("transmit complete interrupt mismatch");

  dre_irq_a: assert property (O_IRQ_DRE == (status_byte[BIT_DRE] && st_reg.ctrl[BIT_DRE]))
    else $error("buffer empty interrupt mismatch");

  bresp_a: assert property (I_CE && st_reg.aw_full && st_reg.w_full && !st_reg.bvalid
                            |=> O_AXI_BVALID)
    else $error("write response missing");

  write_path_c: cover property (I_CE && wr_lo ##[1:4] load);
  frame_end_c:  cover property (I_CE && frame_end && !st_reg.buf_full);
  loop_c:       cover property (st_reg.ctrl[BIT_LOOP] && st_reg.tx_state == TX_SHIFT);
  lin_bad_c:    cover property (O_IRQ_RXC && st_reg.isf);

endmodule
`default_nettype wire

// >>> utx_pkg.sv
// Package with register map, field layout, reset values and types of the serial transmitter.
package utx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam int          AXI_ADDR_W   = 8;
  localparam logic [5:0]  IDX_TX_LOW   = 6'h02;
  localparam logic [5:0]  IDX_TX_HIGH  = 6'h03;
  localparam logic [5:0]  IDX_STATUS   = 6'h04;
  localparam logic [5:0]  IDX_CTRL     = 6'h05;
  localparam logic [5:0]  IDX_CONFIG   = 6'h06;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int BIT_RXC       = 7;
  localparam int BIT_TXC       = 6;
  localparam int BIT_DRE       = 5;
  localparam int BIT_RXS       = 4;
  localparam int BIT_ISF       = 3;
  localparam int BIT_LOOP      = 3;
  localparam int BIT_ABE       = 2;
  localparam int BIT_BDF       = 1;
  localparam int BIT_WFB       = 0;
  localparam int CFG_SOF_EN    = 6;
  localparam int CFG_HOST_SPI  = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, masks and encodings.
  localparam logic [7:0]  CTRL_RST         = 8'h00;
  localparam logic [7:0]  CTRL_MASK        = 8'hfd;
  localparam logic [7:0]  CFG_RST          = 8'h03;
  localparam logic [7:0]  CFG_MASK         = 8'hf7;
  localparam logic [7:0]  STATUS_RST       = 8'h20;
  localparam logic [2:0]  CW_NINE_LOW      = 3'h6;
  localparam logic [2:0]  CW_NINE_HIGH     = 3'h7;
  localparam logic [1:0]  MODE_GENERIC_AB  = 2'h2;
  localparam logic [1:0]  MODE_LIN_AB      = 2'h3;
  localparam logic [7:0]  SYNC_CHAR        = 8'h55;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam logic [15:0] CLKS_PER_BIT_DEF = 16'h0010;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } utx_tx_state_t;

  typedef struct packed {
    logic          aw_full;
    logic          aw_rdy;
    logic [7:0]    aw_addr;
    logic          w_full;
    logic          w_rdy;
    logic [7:0]    w_data;
    logic          w_strb0;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          ar_rdy;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [7:0]    rdata;
    logic [7:0]    tx_low;
    logic          tx_high;
    logic [8:0]    buf_data;
    logic          buf_full;
    utx_tx_state_t tx_state;
    logic [8:0]    sh_data;
    logic [3:0]    bits_left;
    logic [15:0]   baud_cnt;
    logic          txd;
    logic [7:0]    ctrl;
    logic [7:0]    cfg;
    logic          rxc;
    logic          txc;
    logic          rxs;
    logic          isf;
    logic          bdf;
    logic          await_break;
    logic          rx_s1;
    logic          rx_s2;
    logic          rx_line;
    logic          irq_rxc;
    logic          irq_dre;
    logic          irq_txc;
  } utx_state_t;

  localparam utx_state_t ST_RST = '{tx_state: TX_IDLE, txd: 1'b1, ctrl: CTRL_RST, cfg: CFG_RST,
                                    rx_s1: 1'b1, rx_s2: 1'b1, rx_line: 1'b1, default: '0};

endpackage

// >>> utx_remote_peer.sv
// Remote serial partner: receives frames from the transmit pin and drives the receive pin.
`timescale 1ns/1ps
`default_nettype none
module utx_remote_peer #(
  parameter int CPB = 4
) (
  // Line side
  input  wire logic       clk,
  input  wire logic       txd,
  input  wire logic       hold_low,
  output logic            rxd,
  // Frame report
  input  wire logic [3:0] nbits,
  output var logic [8:0]  last,
  output var int          cnt
);
  int i;
  initial begin
    cnt = 0;
    last = '0;
  end
  // The far line idles high like a pulled-up wire; a held-low line stands for a break.
  assign rxd = !hold_low;
  // Samples each bit mid-cell; a frame counts only with a high stop bit.
  always begin
    @(negedge txd);
    repeat (CPB / 2) @(posedge clk);
    if (txd === 1'b0) begin
      for (i = 0; i < int'(nbits); i++) begin
        repeat (CPB) @(posedge clk);
        last[i] = txd;
      end
      repeat (CPB) @(posedge clk);
      if (txd === 1'b1) cnt++;
    end
  end
endmodule
`default_nettype wire

// >>> utx_serial_tx_tb.sv
// Self-checking testbench of the serial transmitter, register bus and flags.
`timescale 1ns/1ps
`default_nettype none
module utx_serial_tx_tb;
  import utx_pkg::*;
  localparam int CPB = 4;
  localparam logic [7:0] A_LO = 8'h08, A_HI = 8'h0c, A_ST = 8'h10, A_CT = 8'h14, A_CF = 8'h18;
  logic I_CLK_SYS = 1'b0, I_RST = 1'b1, I_CE = 1'b1, hold_low = 1'b0;
  logic [7:0] I_AXI_AWADDR = '0, I_AXI_ARADDR = '0, I_SYNC_CHAR = '0;
  logic [31:0] I_AXI_WDATA = '0, O_AXI_RDATA;
  logic [3:0] I_AXI_WSTRB = 4'hf, nbits = 4'h8;
  logic I_AXI_AWVALID = '0, I_AXI_WVALID = '0, I_AXI_BREADY = '0;
  logic I_AXI_ARVALID = '0, I_AXI_RREADY = '0, I_RX_UNREAD = '0, I_STANDBY = '0;
  logic [4:0] ev = '0;
  logic [1:0] O_AXI_BRESP, O_AXI_RRESP, O_RX_SPEED_MODE;
  logic O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID;
  logic O_TXD, O_RX_LINE, O_AWAIT_BREAK, O_IRQ_RXC, O_IRQ_DRE, O_IRQ_TXC, I_RXD;
  logic [8:0] last;
  int cnt, mismatches = 0, comparisons = 0;
  wire logic I_SOF_DET = ev[0];
  wire logic I_SYNC_BAD_LEN = ev[1];
  wire logic I_SYNC_VALID = ev[2];
  wire logic I_BREAK_SYNC = ev[3];
  wire logic I_RX_DATA_DONE = ev[4];

  utx_serial_tx #(.CLKS_PER_BIT(16'(CPB))) i_dut (.*);
  utx_remote_peer #(.CPB(CPB)) i_peer (.clk(I_CLK_SYS), .txd(O_TXD), .hold_low(hold_low),
    .rxd(I_RXD), .nbits(nbits), .last(last), .cnt(cnt));

  initial begin
    forever #5 I_CLK_SYS = ~I_CLK_SYS;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK_SYS);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // The address and data channels are each released only at the edge where their ready is seen high.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge I_CLK_SYS);
    I_AXI_AWADDR <= a;
    I_AXI_WDATA <= {24'h0, d};
    I_AXI_AWVALID <= 1'b1;
    I_AXI_WVALID <= 1'b1;
    I_AXI_BREADY <= 1'b1;
    repeat (50) begin
      @(posedge I_CLK_SYS);
      if (I_AXI_AWVALID && O_AXI_AWREADY) I_AXI_AWVALID <= 1'b0;
      if (I_AXI_WVALID && O_AXI_WREADY) I_AXI_WVALID <= 1'b0;
      if (O_AXI_BVALID) break;
    end
    I_AXI_BREADY <= 1'b0;
    chk(O_AXI_BRESP, r);
    tick(2);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
    @(posedge I_CLK_SYS);
    I_AXI_ARADDR <= a;
    I_AXI_ARVALID <= 1'b1;
    I_AXI_RREADY <= 1'b1;
    repeat (50) begin
      @(posedge I_CLK_SYS);
      if (I_AXI_ARVALID && O_AXI_ARREADY) I_AXI_ARVALID <= 1'b0;
      if (O_AXI_RVALID) break;
    end
    I_AXI_RREADY <= 1'b0;
    chk(O_AXI_RDATA, {24'h0, e});
    chk(O_AXI_RRESP, r);
  endtask

  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge I_CLK_SYS);
    ev[b] <= 1'b0;
    tick(2);
  endtask

  task automatic frames(input int n);
    for (int k = 0; k < 400 && cnt < n; k++) @(posedge I_CLK_SYS);
    chk(cnt, n);
    tick(CPB + 4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // The watchdog allows many times the expected run of well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge I_CLK_SYS);
    mismatches++;
    close_out();
  end

  initial begin
    tick(6);
    I_RST <= 1'b0;
    rc(A_ST, 8'h20);
    rc(A_CT, 8'h00);
    rc(8'h1c, 8'h00, RESP_SLVERR);
    wr(8'h09, 8'hff, RESP_SLVERR);
    rc(A_LO, 8'h00);
    done("reset");
    wr(A_CT, 8'h60);
    chk(O_IRQ_DRE, 1'b1);
    wr(A_LO, 8'ha5);
    wr(A_LO, 8'h5a);
    rc(A_ST, 8'h00);
    chk(O_IRQ_DRE, 1'b0);
    frames(2);
    chk(last, 9'h05a);
    rc(A_ST, 8'h60);
    chk(O_IRQ_TXC, 1'b1);
    wr(A_CT, 8'h20);
    chk(O_IRQ_TXC, 1'b0);
    wr(A_CT, 8'h40);
    chk(O_IRQ_DRE, 1'b0);
    wr(A_ST, 8'h40);
    chk(O_IRQ_TXC, 1'b0);
    rc(A_ST, 8'h20);
    done("eight bit");
    nbits <= 4'h9;
    wr(A_CF, 8'h06);
    wr(A_LO, 8'h3c);
    tick(2 * CPB);
    chk(O_TXD, 1'b1);
    wr(A_HI, 8'h01);
    frames(3);
    chk(last, 9'h13c);
    wr(A_CF, 8'h07);
    wr(A_HI, 8'h00);
    tick(2 * CPB);
    chk(O_TXD, 1'b1);
    wr(A_LO, 8'hc3);
    frames(4);
    chk(last, 9'h0c3);
    wr(A_ST, 8'h40);
    nbits <= 4'h8;
    done("nine bit");
    wr(A_CF, 8'h03);
    wr(A_CT, 8'h00);
    I_RX_UNREAD <= 1'b1;
    tick(2);
    rc(A_ST, 8'ha0);
    chk(O_IRQ_RXC, 1'b0);
    wr(A_CT, 8'h80);
    chk(O_IRQ_RXC, 1'b1);
    I_RX_UNREAD <= 1'b0;
    tick(2);
    chk(O_IRQ_RXC, 1'b0);
    wr(A_CF, 8'h43);
    I_STANDBY <= 1'b1;
    pulse(0);
    rc(A_ST, 8'h30);
    wr(A_CT, 8'h10);
    chk(O_IRQ_RXC, 1'b1);
    wr(A_ST, 8'h10);
    chk(O_IRQ_RXC, 1'b0);
    I_STANDBY <= 1'b0;
    wr(A_CF, 8'h23);
    chk(O_RX_SPEED_MODE, MODE_GENERIC_AB);
    pulse(1);
    rc(A_ST, 8'h28);
    wr(A_CT, 8'h04);
    chk(O_IRQ_RXC, 1'b1);
    chk(O_IRQ_DRE, 1'b0);
    wr(A_ST, 8'h08);
    chk(O_IRQ_RXC, 1'b0);
    wr(A_CF, 8'h33);
    I_SYNC_CHAR <= SYNC_CHAR;
    pulse(2);
    rc(A_ST, 8'h20);
    I_SYNC_CHAR <= 8'h54;
    pulse(2);
    rc(A_ST, 8'h28);
    wr(A_ST, 8'h08);
    pulse(3);
    rc(A_ST, 8'h22);
    pulse(4);
    rc(A_ST, 8'h20);
    pulse(3);
    wr(A_ST, 8'h02);
    rc(A_ST, 8'h20);
    done("receive flags");
    wr(A_ST, 8'h01);
    chk(O_AWAIT_BREAK, 1'b1);
    rc(A_ST, 8'h20);
    hold_low <= 1'b1;
    tick(5);
    chk(O_RX_LINE, 1'b0);
    I_CE <= 1'b0;
    hold_low <= 1'b0;
    tick(5);
    chk(O_RX_LINE, 1'b0);
    I_CE <= 1'b1;
    tick(5);
    chk(O_RX_LINE, 1'b1);
    hold_low <= 1'b1;
    tick(5);
    wr(A_CT, 8'h08);
    chk(O_RX_LINE, 1'b1);
    done("loop-back");
    close_out();
  end
endmodule
`default_nettype wire
